// ### lmb_mux.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmb_params.svh"
module lmb_mux
    import lmb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic boot_memory_type_pin_i,
    input wire logic clock_divider_select_pin_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic cpu_req_valid_i,
    input wire logic [19:0] cpu_addr_i,
    input wire logic [15:0] cpu_data_i,
    input wire logic [7:0] cpu_status_i,
    output logic cpu_req_ready_o,
    output logic [7:0] mem_bus_high_byte_o,
    output logic [7:0] mem_bus_low_byte_o,
    output logic mem_bus_oe_o,
    output logic ext_address_pin0_o,
    output logic ext_addr_parity_high_pin_o,
    output logic address_latch_strobe_n_o,
    output logic row_strobe_n_o,
    output logic column_strobe_n_o,
    output logic local_bus_clock_a_o,
    output logic local_bus_clock_b_o,
    output logic cpu_grant_o,
    output logic code_in_ram_o
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] boot_sync_q;
    logic [1:0] div_sync_q;

    // no reset: the pins keep flowing through so the boot load sees them at release
    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i)
        begin
            boot_sync_q <= {boot_sync_q[0], boot_memory_type_pin_i};
            div_sync_q <= {div_sync_q[0], clock_divider_select_pin_i};
        end
    end

    // ---------------------------------------------------------------
    // control register and boot capture
    // ---------------------------------------------------------------
    logic soft_rst_q;
    logic halt_q;
    logic boot_q;
    logic boot_load_q;
    logic [31:0] rdata_d;

    // soft reset self clears after one cycle, then reloads boot flag
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            soft_rst_q <= 1'b0;
            halt_q <= 1'(`LMB_CTRL_RST >> `LMB_CTRL_HALT);
            boot_q <= 1'b0;
            boot_load_q <= 1'b1;
        end
        else if (ce_i)
        begin
            soft_rst_q <= reg_wr_i && reg_addr_i == `LMB_REG_CTRL && reg_wdata_i[`LMB_CTRL_SRST];
            if (soft_rst_q)
            begin
                halt_q <= 1'b1;
                boot_load_q <= 1'b1;
            end
            else if (reg_wr_i && reg_addr_i == `LMB_REG_CTRL)
            begin
                halt_q <= reg_wdata_i[`LMB_CTRL_HALT];
                boot_q <= reg_wdata_i[`LMB_CTRL_BOOT];
            end
            if (boot_load_q)
            begin
                // the synchroniser runs through reset, so its output is the pin
                boot_q <= boot_sync_q[1];
                boot_load_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // cycle sequencer: 16 slots of one memory cycle
    // ---------------------------------------------------------------
    logic [3:0] slot_q;
    lmb_quarter_e quarter;
    logic [3:0] next_slot;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            // parked in the last slot, whose strobe levels equal the reset levels
            slot_q <= 4'hF;
        end
        else if (ce_i)
        begin
            slot_q <= 4'(slot_q + 4'h1);
        end
    end

    assign next_slot = 4'(slot_q + 4'h1);

    always_comb
    begin
        unique case (next_slot[3:2])
            2'h0: quarter = LMB_Q1;
            2'h1: quarter = LMB_Q2;
            2'h2: quarter = LMB_Q3;
            default: quarter = LMB_Q4;
        endcase
    end

    // ---------------------------------------------------------------
    // request buffer
    // ---------------------------------------------------------------
    lmb_req_s fifo_in;
    lmb_req_s fifo_out;
    logic fifo_valid;
    logic fifo_take;
    logic fifo_in_ready;
    lmb_req_s cur_q;
    logic active_q;
    logic grant;

    assign fifo_in = '{addr: cpu_addr_i, data: cpu_data_i, status: cpu_status_i};
    // a RAM boot keeps the processor off the bus until halt is cleared
    assign grant = !(boot_q && halt_q);
    assign fifo_take = grant && fifo_valid && slot_q == 4'hE;

    lmb_fifo #(
        .WIDTH($bits(lmb_req_s)),
        .DEPTH(`LMB_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_data_i(fifo_in),
        .in_valid_i(cpu_req_valid_i),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_take)
    );

    // loaded one slot early so the pins for slot 0 already carry the new address
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_q <= '0;
            active_q <= 1'b0;
            cpu_grant_o <= 1'b0;
            cpu_req_ready_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cpu_grant_o <= grant;
            cpu_req_ready_o <= fifo_in_ready;
            if (slot_q == 4'hE)
            begin
                active_q <= fifo_take;
                if (fifo_take)
                begin
                    cur_q <= fifo_out;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // pin multiplexer
    // ---------------------------------------------------------------
    // bus line 0 is the msb: reverse every field onto the pins
    function automatic logic [7:0] msb_first(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            msb_first[i] = v[7-i];
        end
    endfunction : msb_first

    lmb_pins_s pins_d;
    logic [7:0] addr_lo7;

    // addr[19:15] are extended bits 4..0, addr[14:0] word bits a14..a0
    assign addr_lo7 = {cur_q.addr[19], cur_q.addr[6:0]};

    // pins are registered, so compute the contents of the next slot
    always_comb
    begin
        pins_d = '0;
        unique case (quarter)
            LMB_Q1:
            begin
                pins_d.high_byte = msb_first(addr_lo7);
                pins_d.low_byte = msb_first(cur_q.addr[14:7]);
                pins_d.ext0 = cur_q.addr[15];
                pins_d.ext_parity_high = cur_q.addr[16];
            end
            LMB_Q2:
            begin
                pins_d.high_byte = msb_first(cur_q.status);
                pins_d.low_byte = msb_first(addr_lo7);
                pins_d.ext0 = cur_q.addr[12];
                pins_d.ext_parity_high = cur_q.addr[15];
            end
            LMB_Q3, LMB_Q4:
            begin
                pins_d.high_byte = msb_first(cur_q.data[7:0]);
                pins_d.low_byte = msb_first(cur_q.data[15:8]);
                pins_d.ext0 = cur_q.addr[12];
                pins_d.ext_parity_high = ~^cur_q.data[7:0];
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mem_bus_high_byte_o <= 8'h00;
            mem_bus_low_byte_o <= 8'h00;
            ext_address_pin0_o <= 1'b0;
            ext_addr_parity_high_pin_o <= 1'b0;
            mem_bus_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            mem_bus_high_byte_o <= pins_d.high_byte;
            mem_bus_low_byte_o <= pins_d.low_byte;
            ext_address_pin0_o <= pins_d.ext0;
            ext_addr_parity_high_pin_o <= pins_d.ext_parity_high;
            mem_bus_oe_o <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // strobes and local bus clocks
    // ---------------------------------------------------------------
    // slots are registered one ahead, so decode next_slot
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            address_latch_strobe_n_o <= 1'b1;
            row_strobe_n_o <= 1'b1;
            column_strobe_n_o <= 1'b1;
            local_bus_clock_a_o <= 1'b0;
            local_bus_clock_b_o <= 1'b0;
            code_in_ram_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // falls after the address settles for two slots
            address_latch_strobe_n_o <= !(next_slot[3:0] >= 4'h2 && next_slot[3:0] < 4'h4);
            row_strobe_n_o <= !(next_slot[3:0] < 4'(`LMB_ROW_SLOTS));
            column_strobe_n_o <= !(active_q && next_slot[3:0] >= 4'(`LMB_ROW_SLOTS) &&
                next_slot[3:0] < 4'(`LMB_ROW_SLOTS + `LMB_COL_SLOTS));
            // two bus clock periods per memory cycle; b lags by a quarter
            local_bus_clock_a_o <= next_slot[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
            local_bus_clock_b_o <= next_slot[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hD};
            code_in_ram_o <= boot_q;
        end
    end

    // ---------------------------------------------------------------
    // register read port
    // ---------------------------------------------------------------
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        unique case (reg_addr_i)
            `LMB_REG_CTRL: rdata_d = {29'h0, boot_q, halt_q, 1'b0};
            `LMB_REG_ADDR: rdata_d = {12'h000, cur_q.addr};
            `LMB_REG_DATA: rdata_d = {16'h0000, cur_q.data};
            // divider pin shows in status so software can flag a bad board
            `LMB_REG_STAT: rdata_d = {24'h0, slot_q, fifo_valid, div_sync_q[1], active_q, grant};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_ras_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && $fell(row_strobe_n_o) |-> !row_strobe_n_o[*5] ##1 row_strobe_n_o)
        else $error("row strobe width wrong");
    a_cas_after_ras: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(column_strobe_n_o) |-> !$past(row_strobe_n_o) && row_strobe_n_o && slot_q == 4'h5)
        else $error("column strobe misplaced");
    a_halt_blocks: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && boot_q && halt_q |=> !cpu_grant_o)
        else $error("grant while halted");
    a_latch_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(address_latch_strobe_n_o) |-> slot_q == 4'h2)
        else $error("latch strobe fell off slot 2");
    a_clk_b_lag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && $rose(local_bus_clock_a_o) |-> ##2 $rose(local_bus_clock_b_o))
        else $error("clock b does not lag a");
    a_ext0_col: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && slot_q >= 4'h3 && slot_q <= 4'hD |=> ext_address_pin0_o == cur_q.addr[12])
        else $error("ext pin 0 wrong in column time");
    a_boot_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && boot_load_q |=> boot_q == $past(boot_sync_q[1]))
        else $error("boot flag not loaded");
    a_slot_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i |=> slot_q == 4'($past(slot_q) + 4'h1))
        else $error("slot counter skipped");
    a_ras_high_mid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        slot_q == 4'h8 |-> row_strobe_n_o)
        else $error("row strobe low late");
endmodule : lmb_mux
`default_nettype wire

// ### lmb_params.svh
`ifndef LMB_PARAMS_SVH
`define LMB_PARAMS_SVH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define LMB_REG_CTRL 4'h0
`define LMB_REG_ADDR 4'h4
`define LMB_REG_DATA 4'h8
`define LMB_REG_STAT 4'hC
// control register fields
`define LMB_CTRL_SRST 0
`define LMB_CTRL_HALT 1
`define LMB_CTRL_BOOT 2
`define LMB_CTRL_RST 16'h0002
// ---------------------------------------------------------------
// timing: one memory cycle is 16 sixteenth slots
// ---------------------------------------------------------------
`define LMB_SLOTS 16
`define LMB_ROW_SLOTS 5
`define LMB_COL_SLOTS 3
`define LMB_Q_SLOTS 4
`define LMB_FIFO_DEPTH 8
`endif

// ### lmb_pkg.sv
package lmb_pkg;
    typedef enum logic [3:0]
    {
        LMB_Q1 = 4'h1,
        LMB_Q2 = 4'h2,
        LMB_Q3 = 4'h4,
        LMB_Q4 = 4'h8
    } lmb_quarter_e;

    typedef struct packed
    {
        logic [19:0] addr;
        logic [15:0] data;
        logic [7:0] status;
    } lmb_req_s;

    typedef struct packed
    {
        logic [7:0] high_byte;
        logic [7:0] low_byte;
        logic ext0;
        logic ext_parity_high;
    } lmb_pins_s;
endpackage : lmb_pkg

// ### lmb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module lmb_fifo #(
    parameter int WIDTH = 44,
    parameter int DEPTH = 8
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // read data registered; pop when output slot is free or being taken
    // the output register is one of the DEPTH places, else nine words would fit
    assign in_ready_o = (cnt_q + {{AW{1'b0}}, out_valid_o}) != (AW+1)'(DEPTH);
    assign push = in_valid_i && in_ready_o;
    assign pop = (cnt_q != '0) && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (ce_i && push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else if (ce_i)
        begin
            if (push)
            begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (pop)
            begin
                rd_q <= AW'(rd_q + 1'b1);
                out_data_o <= mem_q[rd_q];
                out_valid_o <= 1'b1;
            end
            else if (out_ready_i)
            begin
                out_valid_o <= 1'b0;
            end
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : lmb_fifo
`default_nettype wire

// ### lmb_latch_model.sv
`timescale 1ns/10ps
`default_nettype none
module lmb_latch_model
(
    input wire logic [7:0] mem_bus_high_byte_i,
    input wire logic [7:0] mem_bus_low_byte_i,
    input wire logic mem_bus_oe_i,
    input wire logic ext_address_pin0_i,
    input wire logic ext_addr_parity_high_pin_i,
    input wire logic address_latch_strobe_n_i,
    output logic [19:0] latched_addr_o
);
    logic [7:0] hb;
    logic [7:0] lb;
    logic [7:0] hf;
    logic [7:0] lf;
    // an undriven bus reads inverted so a stale value cannot pass for a held one
    assign hb = mem_bus_oe_i ? mem_bus_high_byte_i : ~mem_bus_high_byte_i;
    assign lb = mem_bus_oe_i ? mem_bus_low_byte_i : ~mem_bus_low_byte_i;
    assign hf = {<<{hb}};
    assign lf = {<<{lb}};
    // three transparent byte latches, open while the strobe is high, closed on its fall
    always_latch
    begin
        if (address_latch_strobe_n_i)
        begin
            latched_addr_o <= {hf[7], 2'b00, ext_addr_parity_high_pin_i, ext_address_pin0_i, lf, hf[6:0]};
        end
    end
endmodule : lmb_latch_model
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmb_params.svh"
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb
    import lmb_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic boot_pin = 1'b1;
    logic [3:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic cpu_req_valid_i = 1'b0;
    lmb_req_s req_i = '0;
    logic [31:0] reg_rdata_o;
    logic cpu_req_ready_o, mem_bus_oe_o, ext_address_pin0_o, ext_addr_parity_high_pin_o;
    logic [7:0] mem_bus_high_byte_o, mem_bus_low_byte_o;
    logic address_latch_strobe_n_o, row_strobe_n_o, column_strobe_n_o;
    logic local_bus_clock_a_o, local_bus_clock_b_o, cpu_grant_o, code_in_ram_o;
    logic [19:0] latched_addr;
    logic [42:0] h [16];
    lmb_req_s exp_q [$];
    int failures = 0;
    int n_tests = 0;
    int n_cycles = 0;
    int wait_cnt = 0;
    int cyc = 0;
    logic [31:0] d;

    always #20 clk_sys_i = ~clk_sys_i;

    lmb_mux i_lmb_mux (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
        .boot_memory_type_pin_i(boot_pin), .clock_divider_select_pin_i(1'b1),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cpu_req_valid_i(cpu_req_valid_i), .cpu_addr_i(req_i.addr),
        .cpu_data_i(req_i.data), .cpu_status_i(req_i.status), .cpu_req_ready_o(cpu_req_ready_o),
        .mem_bus_high_byte_o(mem_bus_high_byte_o), .mem_bus_low_byte_o(mem_bus_low_byte_o),
        .mem_bus_oe_o(mem_bus_oe_o), .ext_address_pin0_o(ext_address_pin0_o),
        .ext_addr_parity_high_pin_o(ext_addr_parity_high_pin_o),
        .address_latch_strobe_n_o(address_latch_strobe_n_o), .row_strobe_n_o(row_strobe_n_o),
        .column_strobe_n_o(column_strobe_n_o), .local_bus_clock_a_o(local_bus_clock_a_o),
        .local_bus_clock_b_o(local_bus_clock_b_o), .cpu_grant_o(cpu_grant_o), .code_in_ram_o(code_in_ram_o));

    lmb_latch_model i_lmb_latch_model (.mem_bus_high_byte_i(mem_bus_high_byte_o),
        .mem_bus_low_byte_i(mem_bus_low_byte_o), .mem_bus_oe_i(mem_bus_oe_o),
        .ext_address_pin0_i(ext_address_pin0_o), .ext_addr_parity_high_pin_i(ext_addr_parity_high_pin_o),
        .address_latch_strobe_n_i(address_latch_strobe_n_o), .latched_addr_o(latched_addr));

    // ---------------------------------------------------------------
    // expectations
    // ---------------------------------------------------------------
    function automatic logic [7:0] rev8(input logic [7:0] f);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = f[7 - i];
        end
    endfunction : rev8

    function automatic lmb_req_s mk_req(input int i);
        lmb_req_s r;
        r.addr = 20'($urandom);
        r.data = 16'($urandom);
        r.status = 8'($urandom);
        if (i == 0)
        begin
            r = {20'hFFFFF, 16'hFFFF, 8'hFF};
        end
        else if (i == 1)
        begin
            r = {20'h18000, 16'h0001, 8'h00};
        end
        return r;
    endfunction : mk_req

    task automatic check_cycle();
        lmb_req_s r;
        logic [42:0] v;
        logic [7:0] a1, eh, el;
        logic [4:0] ec;
        if (exp_q.size() == 0)
        begin
            failures++;
            $display("[FAIL] memory cycle expected none seen one");
            return;
        end
        r = exp_q.pop_front();
        a1 = rev8({r.addr[19], r.addr[6:0]});
        // h[12 - s] holds slot s of the cycle just seen
        for (int s = 0; s < 13; s++)
        begin
            v = h[12 - s];
            eh = (s < 4) ? a1 : (s < 8) ? rev8(r.status) : rev8(r.data[7:0]);
            el = (s < 4) ? rev8(r.addr[14:7]) : (s < 8) ? a1 : rev8(r.data[15:8]);
            ec = {s % 8 < 4, (s + 6) % 8 < 4, s != 2 && s != 3, s > 4, s < 5 || s > 7};
            `CHK("high_byte", eh, v[15:8])
            `CHK("low_byte", el, v[7:0])
            `CHK("strobes_clocks", ec, v[22:18])
        end
        `CHK("ext0_row", r.addr[15], h[12][17])
        `CHK("ext0_col", r.addr[12], h[4][17])
        `CHK("par_q1", r.addr[16], h[12][16])
        `CHK("par_q2", r.addr[15], h[8][16])
        `CHK("par_data", ~^r.data[7:0], h[4][16])
        `CHK("latched", r.addr & 20'h9FFFF, h[9][42:23])
    endtask : check_cycle

    // a cycle is found by the column strobe's fall in slot 5 and judged at slot 12
    always @(negedge clk_sys_i)
    begin
        for (int i = 15; i > 0; i--)
        begin
            h[i] = h[i - 1];
        end
        h[0] = {latched_addr, local_bus_clock_a_o, local_bus_clock_b_o, address_latch_strobe_n_o,
                row_strobe_n_o, column_strobe_n_o, ext_address_pin0_o, ext_addr_parity_high_pin_o,
                mem_bus_high_byte_o, mem_bus_low_byte_o};
        if (wait_cnt == 1)
        begin
            check_cycle();
        end
        if (wait_cnt > 0)
        begin
            wait_cnt--;
        end
        if (!rst_i && h[1][18] === 1'b1 && h[0][18] === 1'b0)
        begin
            wait_cnt = 7;
            n_cycles++;
        end
    end

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        v = reg_rdata_o;
    endtask : reg_rd

    // ready lags the fill level by a cycle, so each push leaves one idle edge behind it
    task automatic push(input lmb_req_s r);
        int k;
        k = 0;
        @(negedge clk_sys_i);
        while (cpu_req_ready_o !== 1'b1 && k < 600)
        begin
            @(negedge clk_sys_i);
            k++;
        end
        exp_q.push_back(r);
        @(posedge clk_sys_i);
        cpu_req_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_sys_i);
        cpu_req_valid_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : push

    task automatic wait_cycles(input int n);
        int k;
        k = 0;
        while (n_cycles < n && k < 2000)
        begin
            @(posedge clk_sys_i);
            k++;
        end
        repeat (10) @(posedge clk_sys_i);
        `CHK("cycles", n, n_cycles)
    endtask : wait_cycles

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            failures++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        void'($urandom(32649));
        reg_rd(`LMB_REG_CTRL, d);
        `CHK("ctrl_reset", 3'b110, d[2:0])
        `CHK("code_in_ram", 1'b1, code_in_ram_o)
        reg_rd(`LMB_REG_STAT, d);
        `CHK("stat_reset", 3'b100, d[2:0])
        reg_rd(4'h6, d);
        `CHK("unmapped", 32'h0, d)
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            push(mk_req(i));
        end
        @(negedge clk_sys_i);
        `CHK("fifo_full", 1'b0, cpu_req_ready_o)
        repeat (40) @(posedge clk_sys_i);
        `CHK("halted_cycles", 0, n_cycles)
        `CHK("halted_grant", 1'b0, cpu_grant_o)
        $display("test halted fill done");
        reg_wr(`LMB_REG_CTRL, 32'h4);
        wait_cycles(8);
        `CHK("grant", 1'b1, cpu_grant_o)
        $display("test drain done");
        for (int i = 0; i < 12; i++)
        begin
            push(mk_req(3));
        end
        wait_cycles(20);
        $display("test random done");
        boot_pin <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        reg_wr(`LMB_REG_CTRL, 32'h1);
        repeat (6) @(posedge clk_sys_i);
        reg_rd(`LMB_REG_CTRL, d);
        `CHK("soft_reset_ctrl", 2'b01, d[2:1])
        `CHK("rom_code", 1'b0, code_in_ram_o)
        `CHK("rom_grant", 1'b1, cpu_grant_o)
        push(mk_req(3));
        wait_cycles(21);
        $display("test soft reset done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
